// ---- usrs_evt_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface usrs_evt_if;
	logic [3:0] pins;
	logic [3:0] level;
	logic [3:0] changed;
	logic clr;
	modport src (input pins, clr, output level, changed);
	modport dst (output pins, clr, input level, changed);
endinterface : usrs_evt_if
`default_nettype wire

// ---- usrs_modem.sv ----
`timescale 1ns/100ps
`default_nettype none
module usrs_modem (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Modem lines
	usrs_evt_if.src ev
);
	logic [3:0] level_q;
	logic [3:0] changed_q;
	logic started_q;
	assign ev.level = level_q;
	assign ev.changed = changed_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_q <= 4'h0;
			started_q <= 1'b0;
		end else begin
			level_q <= ev.pins;
			started_q <= 1'b1;
		end
	end
	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_chg
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					changed_q[i] <= 1'b0;
				end else if (started_q && (ev.pins[i] != level_q[i])) begin
					changed_q[i] <= 1'b1;
				end else if (ev.clr) begin
					changed_q[i] <= 1'b0;
				end
			end
		end
	endgenerate
endmodule : usrs_modem
`default_nettype wire

// ---- usrs_modem_peer.sv ----
`timescale 1ns/100ps
`default_nettype none
// Remote modem: moves its handshake lines just after an edge
module usrs_modem_peer (
	// Clock
	input wire logic pclk,
	// Requested and driven line levels
	input wire logic [3:0] want,
	output logic [3:0] pins
);
	always @(posedge pclk) begin
		pins <= want;
	end
endmodule : usrs_modem_peer
`default_nettype wire

// ---- usrs_pkg.sv ----
package usrs_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_COMMAND = 8'h00;
	localparam logic [7:0] OFS_IRQ_ON = 8'h08;
	localparam logic [7:0] OFS_IRQ_OFF = 8'h0C;
	localparam logic [7:0] OFS_IRQ_STATE = 8'h10;
	localparam logic [7:0] OFS_CHAN_STATE = 8'h14;
	localparam logic [7:0] OFS_RX_HOLD = 8'h18;
	localparam logic [7:0] OFS_TIMEOUT_VAL = 8'h24;
	localparam logic [7:0] OFS_MODE_CTRL = 8'h60;
	// Reset values
	localparam logic [31:0] RST_IRQ_STATE = 32'h0000_0000;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	// Status / mask / receive holding bit positions and field widths
	localparam int B_RX_READY = 0;
	localparam int B_TX_READY = 1;
	localparam int B_BRK = 2;
	localparam int B_OVR = 5;
	localparam int B_FRAME = 6;
	localparam int B_PAR = 7;
	localparam int B_TMO = 8;
	localparam int B_TX_EMPTY = 9;
	localparam int B_REPEAT = 10;
	localparam int B_DMAFULL = 12;
	localparam int B_NAK = 13;
	localparam int B_CHG_LO = 16;
	localparam int B_MAN = 20;
	localparam int B_LEVEL_LO = 20;
	localparam int B_MAN_ALIAS = 24;
	localparam int B_SYNC_KIND = 15;
	localparam int RX_CHAR_W = 9;
	localparam int TIMEOUT_W = 16;
	// Command register bits
	localparam int C_RST_STATUS = 8;
	localparam int C_START_BREAK = 9;
	localparam int C_START_TMO = 11;
	localparam int C_RST_NAK = 14;
	localparam int C_RETRIG_TMO = 15;
	// Mode control bits
	localparam int M_SPI_SLAVE = 0;
	localparam int M_MULTIDROP = 1;
	localparam int M_RX_EN = 2;
	localparam int M_TX_EN = 3;
	// Mask bits that are implemented
	localparam logic [31:0] IRQ_BITS = 32'h011F_37E7;
endpackage : usrs_pkg

// ---- usrs_status.sv ----
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module usrs_status (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Modem lines: cts, dcd, dsr, ri
	input wire logic [3:0] modem_pins,
	// Datapath events, one-cycle pulses
	input wire logic rx_char_done,
	input wire logic [usrs_pkg::RX_CHAR_W-1:0] rx_char,
	input wire logic rx_sync_kind,
	input wire logic ev_parity,
	input wire logic ev_mdrop_par_one,
	input wire logic ev_frame,
	input wire logic ev_overrun,
	input wire logic ev_break,
	input wire logic ev_timeout,
	input wire logic ev_max_repeat,
	input wire logic ev_underrun,
	input wire logic ev_nak,
	input wire logic ev_manchester,
	// Datapath levels
	input wire logic dma_buffer_full,
	input wire logic tx_holding_empty,
	input wire logic tx_shift_empty,
	// Command pulses towards the datapath
	output logic start_break_cmd,
	output logic start_timeout_cmd,
	output logic retrigger_timeout_cmd,
	output logic tx_holding_taken,
	// Mode levels towards the datapath
	output logic rx_enable,
	output logic tx_enable,
	output logic [usrs_pkg::TIMEOUT_W-1:0] timeout_value,
	// Interrupt
	output logic irq
);
	import usrs_pkg::*;

	function automatic logic bus_hit(input logic [7:0] a, input logic [7:0] ofs);
		bus_hit = (a == ofs);
	endfunction : bus_hit

	logic acc;
	logic wr;
	logic rd;
	logic [31:0] irq_enable_state_q;
	logic [3:0] mode_q;
	logic [TIMEOUT_W-1:0] timeout_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic irq_q;
	logic start_break_q;
	logic start_to_q;
	logic retrig_to_q;
	logic rx_ready_q;
	logic rx_pending_q;
	logic break_req_q;
	logic [RX_CHAR_W-1:0] rx_char_q;
	logic rx_sync_q;
	logic cmd_wr;
	logic csr_rd;
	logic rhr_rd;
	logic [31:0] on_bits;
	logic [31:0] off_bits;
	logic [31:0] chan_state;
	logic [31:0] rd_mux;
	logic addr_ok;
	logic tx_all_empty;
	logic tx_ready_flag;
	logic timeout_flag;
	logic [7:0] st_set;
	logic [7:0] st_clr;
	logic [7:0] st_flag;
	// Command strobes, valid on the taking edge
	logic reset_status_cmd;
	logic reset_nak_cmd;
	logic break_wr;
	logic start_tmo_wr;
	logic retrig_tmo_wr;

	usrs_evt_if ev ();

	// One-wait slave: access phase completes in its second cycle
	assign acc = psel && penable && !pready_q;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;
	assign cmd_wr = wr && bus_hit(paddr, OFS_COMMAND);
	assign csr_rd = rd && bus_hit(paddr, OFS_CHAN_STATE);
	assign rhr_rd = rd && bus_hit(paddr, OFS_RX_HOLD);

	// One strobe per command bit
	assign reset_status_cmd = cmd_wr && pwdata[C_RST_STATUS];
	assign reset_nak_cmd = cmd_wr && pwdata[C_RST_NAK];
	assign break_wr = cmd_wr && pwdata[C_START_BREAK];
	assign start_tmo_wr = cmd_wr && pwdata[C_START_TMO];
	assign retrig_tmo_wr = cmd_wr && pwdata[C_RETRIG_TMO];

	assign on_bits = pwdata | (32'(pwdata[B_MAN_ALIAS]) << B_MAN)
		| (32'(pwdata[B_MAN]) << B_MAN_ALIAS);
	assign off_bits = on_bits;

	// Mask register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_enable_state_q <= RST_IRQ_STATE;
		end else if (wr && bus_hit(paddr, OFS_IRQ_ON)) begin
			irq_enable_state_q <= (irq_enable_state_q | on_bits) & IRQ_BITS;
		end else if (wr && bus_hit(paddr, OFS_IRQ_OFF)) begin
			irq_enable_state_q <= irq_enable_state_q & ~off_bits;
		end
	end

	// Mode and time-out value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= 4'h0;
			timeout_q <= '0;
		end else begin
			if (wr && bus_hit(paddr, OFS_MODE_CTRL)) begin
				mode_q <= pwdata[3:0];
			end
			if (wr && bus_hit(paddr, OFS_TIMEOUT_VAL)) begin
				timeout_q <= pwdata[TIMEOUT_W-1:0];
			end
		end
	end

	// Command pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_break_q <= 1'b0;
			start_to_q <= 1'b0;
			retrig_to_q <= 1'b0;
		end else begin
			start_break_q <= break_wr;
			start_to_q <= start_tmo_wr;
			retrig_to_q <= retrig_tmo_wr;
		end
	end

	// Modem images and change flags
	assign ev.pins = modem_pins;
	assign ev.clr = csr_rd;
	usrs_modem u_modem (
		.pclk(pclk),
		.presetn(presetn),
		.ev(ev)
	);

	// Sticky flags: 0 man, 1 nak, 2 repeat/underrun, 3 timeout, 4 par, 5 frame, 6 ovr, 7 brk
	always_comb begin
		st_set = 8'h00;
		st_clr = 8'h00;
		st_set[0] = ev_manchester;
		st_set[1] = ev_nak;
		st_clr[1] = reset_nak_cmd;
		st_set[2] = mode_q[M_SPI_SLAVE] ? ev_underrun : ev_max_repeat;
		st_set[3] = ev_timeout && (timeout_q != '0);
		st_clr[3] = start_tmo_wr || retrig_tmo_wr;
		st_set[4] = ev_parity || (mode_q[M_MULTIDROP] && ev_mdrop_par_one);
		st_set[5] = ev_frame;
		st_set[6] = ev_overrun;
		st_set[7] = ev_break;
		if (reset_status_cmd) begin
			st_clr = st_clr | 8'hF5;
		end
	end

	usrs_sticky #(.N(8)) u_sticky (
		.pclk(pclk),
		.presetn(presetn),
		.set(st_set),
		.clr(st_clr),
		.flag(st_flag)
	);
	assign timeout_flag = st_flag[3] && (timeout_q != '0);

	// Break request holds tx flags low until transmitter drains
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			break_req_q <= 1'b0;
		end else if (break_wr) begin
			break_req_q <= 1'b1;
		end else if (tx_holding_empty && tx_shift_empty) begin
			break_req_q <= 1'b0;
		end
	end

	// tx-empty needs enabled and both empty; break clears
	assign tx_all_empty = mode_q[M_TX_EN] && tx_holding_empty && tx_shift_empty
		&& !break_req_q;
	// tx-ready follows holding empty while enabled and no break is pending
	assign tx_ready_flag = mode_q[M_TX_EN] && tx_holding_empty && !break_req_q;

	// Receive holding register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_char_q <= '0;
			rx_sync_q <= 1'b0;
		end else if (rx_char_done) begin
			rx_char_q <= rx_char;
			rx_sync_q <= rx_sync_kind;
		end
	end

	// Receiver ready with pending memory across disable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_ready_q <= 1'b0;
			rx_pending_q <= 1'b0;
		end else begin
			// set on character, read clears, set wins
			if (rx_char_done) begin
				rx_pending_q <= 1'b1;
			end else if (rhr_rd) begin
				rx_pending_q <= 1'b0;
			end
			rx_ready_q <= mode_q[M_RX_EN] && (rx_char_done || (rx_pending_q && !rhr_rd));
		end
	end

	always_comb begin
		chan_state = RST_WORD;
		chan_state[B_RX_READY] = rx_ready_q;
		chan_state[B_TX_READY] = tx_ready_flag;
		chan_state[B_BRK] = st_flag[7];
		chan_state[B_OVR] = st_flag[6];
		chan_state[B_FRAME] = st_flag[5];
		chan_state[B_PAR] = st_flag[4];
		chan_state[B_TMO] = timeout_flag;
		chan_state[B_TX_EMPTY] = tx_all_empty;
		chan_state[B_REPEAT] = st_flag[2];
		chan_state[B_DMAFULL] = dma_buffer_full;
		chan_state[B_NAK] = st_flag[1];
		chan_state[B_CHG_LO +: 4] = ev.changed;
		chan_state[B_LEVEL_LO +: 4] = ev.level;
		chan_state[B_MAN_ALIAS] = st_flag[0];
	end

	// Read mux and decode
	always_comb begin
		rd_mux = RST_WORD;
		addr_ok = 1'b1;
		case (paddr)
			OFS_COMMAND: rd_mux = RST_WORD;
			OFS_IRQ_ON: rd_mux = RST_WORD;
			OFS_IRQ_OFF: rd_mux = RST_WORD;
			OFS_IRQ_STATE: rd_mux = irq_enable_state_q;
			OFS_CHAN_STATE: rd_mux = chan_state;
			OFS_RX_HOLD: rd_mux = {16'h0000, rx_sync_q, 6'h00, rx_char_q};
			OFS_TIMEOUT_VAL: rd_mux = {{(32 - TIMEOUT_W){1'b0}}, timeout_q};
			OFS_MODE_CTRL: rd_mux = {28'h000_0000, mode_q};
			default: addr_ok = 1'b0;
		endcase
	end

	// APB answer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= RST_WORD;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= psel && penable && !pready_q;
			pslverr_q <= acc && !addr_ok;
			prdata_q <= rd ? rd_mux : RST_WORD;
		end
	end

	// interrupt: flags gated by mask, modem levels excluded
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(chan_state & irq_enable_state_q & IRQ_BITS
				& ~(32'h0000_000F << B_LEVEL_LO));
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign irq = irq_q;
	assign start_break_cmd = start_break_q;
	assign start_timeout_cmd = start_to_q;
	assign retrigger_timeout_cmd = retrig_to_q;
	assign tx_holding_taken = 1'b0;
	assign rx_enable = mode_q[M_RX_EN];
	assign tx_enable = mode_q[M_TX_EN];
	assign timeout_value = timeout_q;
endmodule : usrs_status
`default_nettype wire

// ---- usrs_status_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module usrs_status_chk (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Side signals
	input wire logic [3:0] modem_pins,
	input wire logic dma_buffer_full,
	input wire logic start_break_cmd,
	input wire logic start_timeout_cmd,
	input wire logic tx_enable,
	input wire logic retrigger_timeout_cmd,
	input wire logic rx_enable,
	input wire logic [usrs_pkg::TIMEOUT_W-1:0] timeout_value,
	input wire logic irq
);
	import usrs_pkg::*;
	wire logic take = psel && penable && !pready;
	wire logic rdn = psel && penable && pready && !pwrite;
	wire logic cmdw = take && pwrite && paddr == OFS_COMMAND;
	wire logic known = paddr inside {OFS_COMMAND, OFS_IRQ_ON, OFS_IRQ_OFF, OFS_IRQ_STATE,
		OFS_CHAN_STATE, OFS_RX_HOLD, OFS_TIMEOUT_VAL, OFS_MODE_CTRL};
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_next: assert property (take |=> pready)
		else $error("no ready after access");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_unmapped_err: assert property (pready && psel |-> pslverr == !known)
		else $error("error response wrong");
	a_data_idle: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("read data outside answer");
	a_mask_alias: assert property (
		rdn && paddr == OFS_IRQ_STATE |-> prdata[B_MAN] == prdata[B_MAN_ALIAS])
		else $error("mask alias bits differ");
	a_mask_bits: assert property (
		rdn && paddr == OFS_IRQ_STATE |-> (prdata & ~IRQ_BITS) == 32'h0000_0000)
		else $error("mask has unused bits");
	a_level_image: assert property (
		rdn && paddr == OFS_CHAN_STATE && $stable(modem_pins) && $past(modem_pins) ==
		$past(modem_pins, 2) |-> prdata[23:20] == modem_pins)
		else $error("modem level image wrong");
	a_dma_image: assert property (
		rdn && paddr == OFS_CHAN_STATE && $stable(dma_buffer_full)
		|-> prdata[B_DMAFULL] == dma_buffer_full)
		else $error("buffer full image wrong");
	a_break_cmd: assert property (
		cmdw && pwdata[C_START_BREAK] |=> start_break_cmd ##1 !start_break_cmd)
		else $error("break command pulse wrong");
	a_tmo_cmd: assert property (cmdw && pwdata[C_START_TMO] |=> start_timeout_cmd)
		else $error("timeout command missing");
	a_tx_follow: assert property (
		take && pwrite && paddr == OFS_MODE_CTRL |=> tx_enable == pwdata[M_TX_EN])
		else $error("transmit enable wrong");
	a_retrig_cmd: assert property (
		cmdw && pwdata[C_RETRIG_TMO] |=> retrigger_timeout_cmd)
		else $error("retrigger command missing");
	a_rx_follow: assert property (
		take && pwrite && paddr == OFS_MODE_CTRL |=> rx_enable == pwdata[M_RX_EN])
		else $error("receive enable wrong");
	a_tmo_value: assert property (
		take && pwrite && paddr == OFS_TIMEOUT_VAL |=> timeout_value == pwdata[TIMEOUT_W-1:0])
		else $error("timeout value wrong");
	cover property (pready && pslverr);
	cover property (irq);
	cover property (start_break_cmd);
endmodule : usrs_status_chk
bind usrs_status usrs_status_chk usrs_status_chk_i (.*);
`default_nettype wire

// ---- usrs_status_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module usrs_status_bench;
	import usrs_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rxd, sync, dfull, the, tse;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r, e, m;
	logic [3:0] want, pins;
	logic [9:0] ev;
	logic [8:0] ch;
	logic [32:0] expq[$];
	int evb[10] = '{7, 7, 6, 5, 2, 8, 10, 13, 24, 10};
	int miscompares = 0;
	int n_checks = 0;
	usrs_modem_peer usrs_modem_peer_i (.pclk(pclk), .want(want), .pins(pins));
	usrs_status usrs_status_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .modem_pins(pins), .rx_char_done(rxd), .rx_char(ch),
		.rx_sync_kind(sync), .ev_parity(ev[0]), .ev_mdrop_par_one(ev[1]), .ev_frame(ev[2]),
		.ev_overrun(ev[3]), .ev_break(ev[4]), .ev_timeout(ev[5]), .ev_max_repeat(ev[6]),
		.ev_nak(ev[7]), .ev_manchester(ev[8]), .ev_underrun(ev[9]), .dma_buffer_full(dfull),
		.tx_holding_empty(the), .tx_shift_empty(tse), .start_break_cmd(),
		.start_timeout_cmd(), .retrigger_timeout_cmd(), .tx_holding_taken(), .rx_enable(),
		.tx_enable(), .timeout_value(), .irq(irq));
	task automatic cmp_word(input logic [32:0] x, input logic [32:0] s);
		n_checks++;
		if (s !== x) begin
			miscompares++;
			$display("mismatch read expected %h seen %h", x, s);
		end
	endtask : cmp_word
	task automatic cmp_bit(input logic x, input logic s);
		n_checks++;
		if (s !== x) begin
			miscompares++;
			$display("mismatch irq expected %b seen %b", x, s);
		end
	endtask : cmp_bit
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [32:0] x);
		expq.push_back(x);
		apb(1'b0, a, 32'h0000_0000);
	endtask : rd
	task automatic pulse(input int i);
		ev[i] <= 1'b1;
		@(posedge pclk);
		ev[i] <= 1'b0;
		@(posedge pclk);
	endtask : pulse
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : close_out
	// Answers popped in order as each read completes
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			cmp_word(expq.pop_front(), {pslverr, prdata});
		end
	end
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		#400000;
		miscompares++;
		close_out();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, want, ev, rxd, ch, sync, dfull} = '0;
		{the, tse} = 2'b11;
		r = $urandom(21);
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(OFS_IRQ_STATE, 33'h0);
		rd(OFS_RX_HOLD, 33'h0);
		rd(8'h04, {1'b1, 32'h0});
		e = 32'h0000_0000;
		for (int k = 0; k < 4; k++) begin
			r = $urandom();
			e = e | (r & IRQ_BITS);
			if (e[B_MAN] | e[B_MAN_ALIAS]) e = e | 32'h0110_0000;
			wr(OFS_IRQ_ON, r);
			rd(OFS_IRQ_STATE, {1'b0, e});
			m = $urandom();
			if (m[B_MAN] | m[B_MAN_ALIAS]) m = m | 32'h0110_0000;
			wr(OFS_IRQ_OFF, m);
			wr(OFS_IRQ_STATE, 32'hFFFF_FFFF);
			e = e & ~m;
			rd(OFS_IRQ_STATE, {1'b0, e});
		end
		wr(OFS_IRQ_OFF, 32'hFFFF_FFFF);
		wr(OFS_MODE_CTRL, 32'h0000_0002);
		wr(OFS_TIMEOUT_VAL, 32'h0000_0005);
		for (int i = 0; i < 9; i++) begin
			pulse(i);
			rd(OFS_CHAN_STATE, 33'h1 << evb[i]);
			wr(OFS_COMMAND, 32'h0000_4900);
			rd(OFS_CHAN_STATE, 33'h0);
		end
		pulse(7);
		pulse(5);
		pulse(2);
		wr(OFS_COMMAND, 32'h0000_0100);
		rd(OFS_CHAN_STATE, 33'h0000_2100);
		wr(OFS_COMMAND, 32'h0000_4000);
		wr(OFS_COMMAND, 32'h0000_8000);
		rd(OFS_CHAN_STATE, 33'h0);
		wr(OFS_TIMEOUT_VAL, 32'h0000_0000);
		pulse(5);
		rd(OFS_CHAN_STATE, 33'h0);
		wr(OFS_MODE_CTRL, 32'h0000_0001);
		pulse(6);
		rd(OFS_CHAN_STATE, 33'h0);
		pulse(9);
		rd(OFS_CHAN_STATE, 33'h0000_0400);
		wr(OFS_COMMAND, 32'h0000_0100);
		wr(OFS_IRQ_ON, 32'h0000_0020);
		pulse(3);
		@(posedge pclk);
		cmp_bit(1'b1, irq);
		wr(OFS_IRQ_OFF, 32'h0000_0020);
		cmp_bit(1'b0, irq);
		wr(OFS_COMMAND, 32'h0000_0100);
		r = $urandom();
		want <= r[3:0] | 4'h1;
		repeat (4) @(posedge pclk);
		rd(OFS_CHAN_STATE, {1'b0, 8'h0, r[3:0] | 4'h1, r[3:0] | 4'h1, 16'h0});
		rd(OFS_CHAN_STATE, {1'b0, 8'h0, r[3:0] | 4'h1, 20'h0});
		wr(OFS_MODE_CTRL, 32'h0000_0004);
		ch <= r[12:4];
		sync <= 1'b1;
		rxd <= 1'b1;
		@(posedge pclk);
		rxd <= 1'b0;
		@(posedge pclk);
		rd(OFS_CHAN_STATE, {1'b0, 8'h0, r[3:0] | 4'h1, 20'h1});
		rd(OFS_RX_HOLD, {1'b0, 16'h0, 1'b1, 6'h0, r[12:4]});
		rd(OFS_CHAN_STATE, {1'b0, 8'h0, r[3:0] | 4'h1, 20'h0});
		wr(OFS_MODE_CTRL, 32'h0000_0008);
		dfull <= 1'b1;
		rd(OFS_CHAN_STATE, {1'b0, 8'h0, r[3:0] | 4'h1, 20'h0_1202});
		the <= 1'b0;
		rd(OFS_CHAN_STATE, {1'b0, 8'h0, r[3:0] | 4'h1, 20'h0_1000});
		the <= 1'b1;
		tse <= 1'b0;
		rd(OFS_CHAN_STATE, {1'b0, 8'h0, r[3:0] | 4'h1, 20'h0_1002});
		wr(OFS_COMMAND, 32'h0000_0200);
		rd(OFS_CHAN_STATE, {1'b0, 8'h0, r[3:0] | 4'h1, 20'h0_1000});
		tse <= 1'b1;
		rd(OFS_CHAN_STATE, {1'b0, 8'h0, r[3:0] | 4'h1, 20'h0_1202});
		rxd <= 1'b1;
		@(posedge pclk);
		rxd <= 1'b0;
		rd(OFS_CHAN_STATE, {1'b0, 8'h0, r[3:0] | 4'h1, 20'h0_1202});
		wr(OFS_MODE_CTRL, 32'h0000_000C);
		rd(OFS_CHAN_STATE, {1'b0, 8'h0, r[3:0] | 4'h1, 20'h0_1203});
		rd(OFS_RX_HOLD, {1'b0, 16'h0, 1'b1, 6'h0, r[12:4]});
		repeat (4) @(posedge pclk);
		close_out();
	end
endmodule : usrs_status_bench
`default_nettype wire

// ---- usrs_sticky.sv ----
`timescale 1ns/100ps
`default_nettype none
module usrs_sticky #(
	parameter int N = 8
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Set and clear per flag
	input wire logic [N-1:0] set,
	input wire logic [N-1:0] clr,
	output logic [N-1:0] flag
);
	logic [N-1:0] flag_q;
	assign flag = flag_q;
	// Set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q <= '0;
		end else begin
			flag_q <= set | (flag_q & ~clr);
		end
	end
endmodule : usrs_sticky
`default_nettype wire
